/* verilog/sbcu_defines.vh */
`ifndef SBCU_DEFINES_VH
`define SBCU_DEFINES_VH

// Operation codes presented by instruction decode.
`define SBCU_OP_NONE          5'h00
`define SBCU_OP_CMP_IMM       5'h01
`define SBCU_OP_SKIP_REG_CLR  5'h02
`define SBCU_OP_SKIP_REG_SET  5'h03
`define SBCU_OP_SKIP_IO_CLR   5'h04
`define SBCU_OP_SKIP_IO_SET   5'h05
`define SBCU_OP_BR_FLAG_SET   5'h06
`define SBCU_OP_BR_FLAG_CLR   5'h07
`define SBCU_OP_BR_EQ         5'h08
`define SBCU_OP_BR_NE         5'h09
`define SBCU_OP_BR_CS         5'h0a
`define SBCU_OP_BR_CC         5'h0b
`define SBCU_OP_BR_SH         5'h0c
`define SBCU_OP_BR_LO         5'h0d
`define SBCU_OP_BR_MI         5'h0e
`define SBCU_OP_BR_PL         5'h0f
`define SBCU_OP_BR_GE         5'h10
`define SBCU_OP_BR_LT         5'h11
`define SBCU_OP_BR_HS         5'h12
`define SBCU_OP_BR_HC         5'h13
`define SBCU_OP_BR_TS         5'h14
`define SBCU_OP_BR_TC         5'h15
`define SBCU_OP_BR_VS         5'h16
`define SBCU_OP_BR_VC         5'h17

// Bit positions inside the status flag byte.
`define SBCU_FLAG_C 0
`define SBCU_FLAG_Z 1
`define SBCU_FLAG_N 2
`define SBCU_FLAG_V 3
`define SBCU_FLAG_S 4
`define SBCU_FLAG_H 5
`define SBCU_FLAG_T 6
`define SBCU_FLAG_I 7

// Flags written by the compare; all others are kept.
`define SBCU_CMP_FLAG_MASK 8'h2f

// Cycle counts of the handled instructions.
`define SBCU_CYC_ONE   2'h1
`define SBCU_CYC_TWO   2'h2
`define SBCU_CYC_THREE 2'h3

// Program counter steps.
`define SBCU_PC_STEP_ONE   16'h0001
`define SBCU_PC_STEP_TWO   16'h0002
`define SBCU_PC_STEP_THREE 16'h0003

// Reset values.
`define SBCU_RESET_PC    16'h0000
`define SBCU_RESET_FLAGS 8'h00

`endif

/* verilog/sbcu_unit.v */
// Function
// - Compare with immediate updates Z, N, V, C, H only, in one cycle.
// - Skip when selected source register bit is 0; PC plus 2 or 3.
// - Skip when selected source register bit is 1; PC plus 2 or 3.
// - Skip when chosen I/O bit reads 0; no flags change.
// - Skip when chosen I/O bit reads 1; one to three cycles.
// - Branch to PC plus offset plus one when indexed flag is 1.
// - Branch to PC plus offset plus one when indexed flag is 0.
// - Equal branches on Z set, not-equal on Z clear.
// - Carry-set branches on C set, carry-clear on C clear.
// - Same-or-higher branches on C clear, lower on C set.
// - Minus branches on N set, plus on N clear.
// - Signed greater-equal on N xor V clear, less-than on it set.
// - Half-carry-set on H set, half-carry-clear on H clear.
// - Transfer-set on T set, transfer-clear on T clear.
// - Overflow-set branches on V set, else falls through.
// - Overflow-clear on V clear; skips and branches keep all flags.
`timescale 1ns/1ns
`default_nettype none
`include "sbcu_defines.vh"

module sbcu_unit (
  input  wire        clk,             // Core clock, 25 MHz.
  input  wire        reset_n,         // Synchronous reset, active low.
  input  wire        op_valid,        // Decode presents an operation.
  output wire        op_ready,        // Unit can take an operation.
  input  wire [4:0]  op_code,         // Operation code.
  input  wire [7:0]  work_register,   // Working register operand.
  input  wire [7:0]  immediate,       // Immediate constant for compare.
  input  wire [7:0]  source_register, // Register tested by skips.
  input  wire [7:0]  io_value,        // Addressed I/O register value.
  input  wire [2:0]  bit_sel,         // Bit tested by skips.
  input  wire [2:0]  flag_sel,        // Flag index for generic branches.
  input  wire [6:0]  offset,          // Signed relative branch offset.
  input  wire        next_two_word,   // Following instruction is two words.
  input  wire [15:0] program_counter, // Address of this instruction.
  input  wire [7:0]  status_flags,    // Current status flags.
  output reg         done,            // Operation finished, one cycle.
  output reg         pc_load,         // Program counter takes pc_next.
  output reg  [15:0] pc_next,         // Next program counter.
  output reg         flags_write,     // Status takes flags_out.
  output reg  [7:0]  flags_out,       // Updated status flags.
  output reg         taken,           // Skip or branch was taken.
  output reg  [1:0]  cycles,          // Cycles the operation used.
  output reg         illegal_op       // Unknown operation code seen.
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg        state;
  reg [1:0]  remain;
  reg        next_state;
  reg [1:0]  next_remain;

  // Intermediate values of the decode.
  reg        is_skip;
  reg        is_branch;
  reg        is_cmp;
  reg        cond;
  reg        known;
  reg [1:0]  op_cycles;
  reg [15:0] op_pc;
  wire       accept;

  // Compare datapath.
  wire [7:0] diff;
  wire       cmp_h;
  wire       cmp_v;
  wire       cmp_c;
  wire       cmp_n;
  wire       cmp_z;
  wire [7:0] cmp_flags;
  wire [7:0] merged_flags;
  wire [15:0] rel_target;
  wire [15:0] seq_pc;
  wire [15:0] skip_pc;

  // Flag shorthands read by the condition decode.
  wire f_c;
  wire f_z;
  wire f_n;
  wire f_v;
  wire f_h;
  wire f_t;
  wire sel_flag;
  wire reg_bit;
  wire io_bit;

  assign f_c = status_flags[`SBCU_FLAG_C];
  assign f_z = status_flags[`SBCU_FLAG_Z];
  assign f_n = status_flags[`SBCU_FLAG_N];
  assign f_v = status_flags[`SBCU_FLAG_V];
  assign f_h = status_flags[`SBCU_FLAG_H];
  assign f_t = status_flags[`SBCU_FLAG_T];
  assign sel_flag = status_flags[flag_sel];
  assign reg_bit = source_register[bit_sel];
  assign io_bit = io_value[bit_sel];

  // The unit takes work only when idle, so a multi-cycle skip or branch
  // stalls decode instead of letting a second operation overlap it.
  assign op_ready = (state == ST_IDLE);
  assign accept = op_valid && op_ready;

  // Subtraction without storing the result; only flags come out.
  assign diff = work_register - immediate;
  assign cmp_h = (~work_register[3] & immediate[3]) |
                 (immediate[3] & diff[3]) |
                 (diff[3] & ~work_register[3]);
  assign cmp_v = (work_register[7] & ~immediate[7] & ~diff[7]) |
                 (~work_register[7] & immediate[7] & diff[7]);
  assign cmp_c = (~work_register[7] & immediate[7]) |
                 (immediate[7] & diff[7]) |
                 (diff[7] & ~work_register[7]);
  assign cmp_n = diff[7];
  assign cmp_z = (diff == 8'h00);

  // Pack the computed flags at their status positions.
  assign cmp_flags[`SBCU_FLAG_C] = cmp_c;
  assign cmp_flags[`SBCU_FLAG_Z] = cmp_z;
  assign cmp_flags[`SBCU_FLAG_N] = cmp_n;
  assign cmp_flags[`SBCU_FLAG_V] = cmp_v;
  assign cmp_flags[`SBCU_FLAG_S] = status_flags[`SBCU_FLAG_S];
  assign cmp_flags[`SBCU_FLAG_H] = cmp_h;
  assign cmp_flags[`SBCU_FLAG_T] = status_flags[`SBCU_FLAG_T];
  assign cmp_flags[`SBCU_FLAG_I] = status_flags[`SBCU_FLAG_I];

  // Only the masked flags take the compare result; the rest pass through.
  // The mask is held as a sized constant so each bit is picked by index.
  localparam [7:0] CMP_MASK = `SBCU_CMP_FLAG_MASK;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag_merge
      assign merged_flags[gi] = CMP_MASK[gi] ? cmp_flags[gi] : status_flags[gi];
    end
  endgenerate

  // Offset is sign extended so backward branches wrap correctly.
  assign rel_target = program_counter + {{9{offset[6]}}, offset} +
                      `SBCU_PC_STEP_ONE;
  assign seq_pc = program_counter + `SBCU_PC_STEP_ONE;
  assign skip_pc = program_counter + (next_two_word ? `SBCU_PC_STEP_THREE :
                                      `SBCU_PC_STEP_TWO);

  // Condition decode for every handled operation.
  always @* begin
    is_skip = 1'b0;
    is_branch = 1'b0;
    is_cmp = 1'b0;
    cond = 1'b0;
    known = 1'b1;
    case (op_code)
      `SBCU_OP_CMP_IMM: begin
        is_cmp = 1'b1;
      end
      `SBCU_OP_SKIP_REG_CLR: begin
        is_skip = 1'b1;
        cond = ~reg_bit;
      end
      `SBCU_OP_SKIP_REG_SET: begin
        is_skip = 1'b1;
        cond = reg_bit;
      end
      `SBCU_OP_SKIP_IO_CLR: begin
        is_skip = 1'b1;
        cond = ~io_bit;
      end
      `SBCU_OP_SKIP_IO_SET: begin
        is_skip = 1'b1;
        cond = io_bit;
      end
      `SBCU_OP_BR_FLAG_SET: begin
        is_branch = 1'b1;
        cond = sel_flag;
      end
      `SBCU_OP_BR_FLAG_CLR: begin
        is_branch = 1'b1;
        cond = ~sel_flag;
      end
      `SBCU_OP_BR_EQ: begin
        is_branch = 1'b1;
        cond = f_z;
      end
      `SBCU_OP_BR_NE: begin
        is_branch = 1'b1;
        cond = ~f_z;
      end
      `SBCU_OP_BR_CS: begin
        is_branch = 1'b1;
        cond = f_c;
      end
      `SBCU_OP_BR_CC: begin
        is_branch = 1'b1;
        cond = ~f_c;
      end
      `SBCU_OP_BR_SH: begin
        is_branch = 1'b1;
        cond = ~f_c;
      end
      `SBCU_OP_BR_LO: begin
        is_branch = 1'b1;
        cond = f_c;
      end
      `SBCU_OP_BR_MI: begin
        is_branch = 1'b1;
        cond = f_n;
      end
      `SBCU_OP_BR_PL: begin
        is_branch = 1'b1;
        cond = ~f_n;
      end
      `SBCU_OP_BR_GE: begin
        is_branch = 1'b1;
        cond = ~(f_n ^ f_v);
      end
      `SBCU_OP_BR_LT: begin
        is_branch = 1'b1;
        cond = f_n ^ f_v;
      end
      `SBCU_OP_BR_HS: begin
        is_branch = 1'b1;
        cond = f_h;
      end
      `SBCU_OP_BR_HC: begin
        is_branch = 1'b1;
        cond = ~f_h;
      end
      `SBCU_OP_BR_TS: begin
        is_branch = 1'b1;
        cond = f_t;
      end
      `SBCU_OP_BR_TC: begin
        is_branch = 1'b1;
        cond = ~f_t;
      end
      `SBCU_OP_BR_VS: begin
        is_branch = 1'b1;
        cond = f_v;
      end
      `SBCU_OP_BR_VC: begin
        is_branch = 1'b1;
        cond = ~f_v;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // Cycle count and program counter follow from kind and condition.
  always @* begin
    op_cycles = `SBCU_CYC_ONE;
    op_pc = seq_pc;
    if (is_branch && cond) begin
      op_cycles = `SBCU_CYC_TWO;
      op_pc = rel_target;
    end else if (is_skip && cond) begin
      op_cycles = next_two_word ? `SBCU_CYC_THREE : `SBCU_CYC_TWO;
      op_pc = skip_pc;
    end
  end

  // Sequencer: holds the unit busy for the extra cycles of an operation.
  always @* begin
    next_state = state;
    next_remain = remain;
    case (state)
      ST_IDLE: begin
        if (accept && op_cycles != `SBCU_CYC_ONE) begin
          next_state = ST_BUSY;
          next_remain = op_cycles - `SBCU_CYC_ONE;
        end
      end
      ST_BUSY: begin
        next_remain = remain - `SBCU_CYC_ONE;
        if (remain == `SBCU_CYC_ONE) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_remain = 2'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      remain <= 2'h0;
    end else begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  // Results are captured at acceptance and held until the next one.
  // Unknown codes still retire in one cycle so decode never hangs.
  always @(posedge clk) begin
    if (!reset_n) begin
      pc_next <= `SBCU_RESET_PC;
      flags_out <= `SBCU_RESET_FLAGS;
      taken <= 1'b0;
      cycles <= 2'h0;
      illegal_op <= 1'b0;
    end else if (accept) begin
      pc_next <= op_pc;
      flags_out <= is_cmp ? merged_flags : status_flags;
      taken <= (is_skip || is_branch) && cond;
      cycles <= op_cycles;
      illegal_op <= ~known;
    end
  end

  // Completion strobes: one cycle, in the last cycle of the operation.
  always @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
      pc_load <= 1'b0;
      flags_write <= 1'b0;
    end else begin
      done <= (accept && op_cycles == `SBCU_CYC_ONE) ||
              (state == ST_BUSY && remain == `SBCU_CYC_ONE);
      pc_load <= (accept && op_cycles == `SBCU_CYC_ONE && known) ||
                 (state == ST_BUSY && remain == `SBCU_CYC_ONE);
      flags_write <= accept && is_cmp;
    end
  end

endmodule

`default_nettype wire

/* tb/sbcu_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sbcu_defines.vh"

module sbcu_checker (
  input wire logic       clk,           // Core clock.
  input wire logic       reset_n,       // Synchronous reset.
  input wire logic       op_valid,      // Decode offers an op.
  input wire logic       op_ready,      // Unit is idle.
  input wire logic [4:0] op_code,       // Operation code.
  input wire logic [7:0] io_value,      // I/O operand.
  input wire logic [2:0] bit_sel,       // Tested bit.
  input wire logic       next_two_word, // Skipped op is long.
  input wire logic [7:0] status_flags,  // Flags in.
  input wire logic       done,          // Retire pulse.
  input wire logic       pc_load,       // Address strobe.
  input wire logic       flags_write,   // Flag strobe.
  input wire logic [7:0] flags_out,     // Flags out.
  input wire logic       taken,         // Condition true.
  input wire logic [1:0] cycles,        // Cycles used.
  input wire logic       illegal_op     // Unknown code.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // An op is accepted only when both sides agree on the same edge.
  wire logic acc = op_valid && op_ready;

  a_cmp_single: assert property (acc && op_code == `SBCU_OP_CMP_IMM |=>
    done && flags_write && pc_load) else $error("compare not single cycle");
  a_cmp_mask: assert property (flags_write |->
    ((flags_out ^ $past(status_flags)) & 8'hd0) == 8'h00) else $error("compare hit S T I");
  a_write_cmp_only: assert property (acc && op_code != `SBCU_OP_CMP_IMM |=>
    !flags_write) else $error("flags written by non compare");
  a_load_done: assert property (pc_load |-> done && !illegal_op)
    else $error("address strobe without retire");
  a_eq_taken: assert property (acc && op_code == `SBCU_OP_BR_EQ &&
    status_flags[`SBCU_FLAG_Z] |=> !done && !op_ready ##1 done && taken && cycles == 2'h2)
    else $error("equal branch timing");
  a_ne_fall: assert property (acc && op_code == `SBCU_OP_BR_NE &&
    status_flags[`SBCU_FLAG_Z] |=> done && !taken && cycles == 2'h1)
    else $error("not equal branch taken");
  a_carry_fall: assert property (acc && op_code == `SBCU_OP_BR_CS &&
    !status_flags[`SBCU_FLAG_C] |=> done && !taken) else $error("carry branch taken");
  a_skip_long: assert property (acc && op_code == `SBCU_OP_SKIP_IO_SET &&
    io_value[bit_sel] && next_two_word |=> !done [*2] ##1 done && cycles == 2'h3)
    else $error("long skip timing");
endmodule

bind sbcu_unit sbcu_checker chk_u (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
  .op_ready(op_ready), .op_code(op_code), .io_value(io_value), .bit_sel(bit_sel),
  .next_two_word(next_two_word), .status_flags(status_flags), .done(done),
  .pc_load(pc_load), .flags_write(flags_write), .flags_out(flags_out), .taken(taken),
  .cycles(cycles), .illegal_op(illegal_op));
`default_nettype wire

/* tb/sbcu_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

module sbcu_core_model (
  input  wire logic        clk,             // Core clock.
  input  wire logic        reset_n,         // Synchronous reset.
  input  wire logic        preset,          // Bench loads a context.
  input  wire logic [15:0] preset_pc,       // Context address.
  input  wire logic [7:0]  preset_flags,    // Context flags.
  input  wire logic        pc_load,         // Unit address strobe.
  input  wire logic [15:0] pc_next,         // Unit address.
  input  wire logic        flags_write,     // Unit flag strobe.
  input  wire logic [7:0]  flags_out,       // Unit flags.
  output var  logic [15:0] program_counter, // Core address.
  output var  logic [7:0]  status_flags     // Core flags.
);
  // Flags move only on preset or the strobe, so a stray write shows as a changed byte.
  always @(posedge clk) begin
    if (!reset_n) begin
      program_counter <= 16'h0000;
      status_flags <= 8'h00;
    end else if (preset) begin
      program_counter <= preset_pc;
      status_flags <= preset_flags;
    end else begin
      if (pc_load) program_counter <= pc_next;
      if (flags_write) status_flags <= flags_out;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_skip_branch_condition_unit.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_skip_branch_condition_unit;
  typedef struct packed {logic [4:0] op; logic [7:0] f; logic tk;} sbcu_row_t;
  logic clk = 1'h0, reset_n = 1'h0, op_valid = 1'h0, preset = 1'h0, next_two_word = 1'h0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] work_register = 8'h10, immediate = 8'h20, source_register = 8'h00;
  logic [7:0] io_value = 8'h00, preset_flags = 8'h00, status_flags, flags_out;
  logic [2:0] bit_sel = 3'h2, flag_sel = 3'h6;
  logic [6:0] offset = 7'h40;
  logic [15:0] program_counter, pc_next;
  logic op_ready, done, pc_load, flags_write, taken, illegal_op;
  logic [1:0] cycles;
  int fails = 0, comparisons = 0;
  // Offset 7'h40 is the most negative step, so targets land at 16'h00c1.
  sbcu_row_t rows [27] = '{'{5'h02,8'h00,1'h1}, '{5'h03,8'h84,1'h1}, '{5'h04,8'h84,1'h0},
    '{5'h04,8'h80,1'h1}, '{5'h05,8'h84,1'h1}, '{5'h05,8'h00,1'h0}, '{5'h06,8'h40,1'h1},
    '{5'h07,8'h40,1'h0}, '{5'h08,8'h02,1'h1}, '{5'h09,8'h02,1'h0}, '{5'h0a,8'h01,1'h1},
    '{5'h0a,8'h00,1'h0}, '{5'h0b,8'h00,1'h1}, '{5'h0c,8'h01,1'h0}, '{5'h0d,8'h00,1'h0},
    '{5'h0e,8'h04,1'h1}, '{5'h0f,8'h04,1'h0}, '{5'h10,8'h0c,1'h1}, '{5'h10,8'h04,1'h0},
    '{5'h11,8'h08,1'h1}, '{5'h11,8'h0c,1'h0}, '{5'h12,8'h00,1'h0}, '{5'h13,8'h20,1'h0},
    '{5'h14,8'h40,1'h1}, '{5'h15,8'hbf,1'h1}, '{5'h16,8'hf7,1'h0}, '{5'h17,8'h08,1'h0}};

  always #20 clk = ~clk;

  sbcu_unit dut_u (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .work_register(work_register), .immediate(immediate),
    .source_register(source_register), .io_value(io_value), .bit_sel(bit_sel),
    .flag_sel(flag_sel), .offset(offset), .next_two_word(next_two_word),
    .program_counter(program_counter), .status_flags(status_flags), .done(done),
    .pc_load(pc_load), .pc_next(pc_next), .flags_write(flags_write), .flags_out(flags_out),
    .taken(taken), .cycles(cycles), .illegal_op(illegal_op));

  sbcu_core_model core_u (.clk(clk), .reset_n(reset_n), .preset(preset),
    .preset_pc(16'h0100), .preset_flags(preset_flags), .pc_load(pc_load), .pc_next(pc_next),
    .flags_write(flags_write), .flags_out(flags_out), .program_counter(program_counter),
    .status_flags(status_flags));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Loads a context, issues one op and follows it to retirement.
  task automatic run(input logic [4:0] op, input logic [7:0] f, input logic tk,
                     input logic [1:0] cy, input logic [15:0] pc, input logic [7:0] fl);
    int n;
    @(negedge clk);
    preset = 1'h1;
    preset_flags = f;
    @(negedge clk);
    preset = 1'h0;
    op_valid = 1'h1;
    op_code = op;
    source_register = f;
    io_value = f;
    next_two_word = f[7];
    @(negedge clk);
    op_valid = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), cy, "retire cycle");
    chk(pc_load, op < 5'h18, "address strobe");
    @(negedge clk);
    chk(taken, tk, "condition");
    chk(cycles, cy, "cycle count");
    chk(illegal_op, op > 5'h17, "illegal flag");
    chk(program_counter, pc, "next address");
    chk(status_flags, fl, "status flags");
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [1:0] cy;
    repeat (20) @(negedge clk);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      cy = !rows[i].tk ? 2'h1 : (rows[i].op >= 5'h06 ? 2'h2 : (rows[i].f[7] ? 2'h3 : 2'h2));
      run(rows[i].op, rows[i].f, rows[i].tk, cy, !rows[i].tk ? 16'h0101 :
          (rows[i].op >= 5'h06 ? 16'h00c1 : 16'h0100 + cy), rows[i].f);
    end
    // 8'h10 minus 8'h20 borrows: C and N set, S keeps its old clear value.
    run(5'h01, 8'h40, 1'h0, 2'h1, 16'h0101, 8'h45);
    run(5'h1f, 8'h00, 1'h0, 2'h1, 16'h0100, 8'h00);
    // A forward step checks the positive side of the signed offset.
    offset = 7'h3f;
    run(5'h0a, 8'h01, 1'h1, 2'h2, 16'h0140, 8'h01);
    @(negedge clk);
    reset_n = 1'h0;
    @(negedge clk);
    chk({pc_load, flags_write, illegal_op, done, taken, cycles, op_ready}, 16'h0001,
        "reset outputs");
    chk(pc_next, 16'h0000, "reset address");
    chk({8'h00, flags_out}, 16'h0000, "reset flags");
    reset_n = 1'h1;
    // The unit must work again straight after a mid-run reset.
    run(5'h09, 8'h00, 1'h1, 2'h2, 16'h0140, 8'h00);
    final_report();
  end

  // The table needs well under 300 cycles; a hang ends the run here.
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
